// file: include/fwrp_pkg.sv
package fwrp_pkg;

    // frame layout, msb first: address, direction, data
    localparam int unsigned FRAME_BITS  = 16;
    localparam int unsigned ADDR_BITS   = 7;
    localparam int unsigned DATA_BITS   = 8;
    localparam logic [4:0]  LAST_ADDR_IX = 5'h06;  // sample index of seventh address bit
    localparam logic [4:0]  DIR_IX       = 5'h07;  // sample index of direction bit
    localparam logic [4:0]  LAST_DATA_IX = 5'h0f;  // sample index of last data bit
    localparam logic [4:0]  BITCNT_RST   = 5'h00;
    localparam logic        DIR_READ     = 1'b1;   // direction bit value for a read

    // page control register
    localparam logic [6:0]  PAGE_CTRL_ADDR = 7'h00;
    localparam logic [7:0]  PAGE_CTRL_RST  = 8'h00; // page 0 holds first_page_low..high registers
    localparam int unsigned PAGE_SEL_BIT   = 0;

    // pin vector positions inside the synchroniser
    localparam int unsigned PIN_SEL = 0;
    localparam int unsigned PIN_SCK = 1;
    localparam int unsigned PIN_SI  = 2;
    localparam logic [2:0]  PIN_RST = 3'h0;

    // static configuration straps
    typedef struct packed {
        logic fourWire;  // 1 enables the 4-wire port, 0 leaves the port disabled
        logic cpol;      // idle level of host_serial_clock
        logic cpha;      // clock phase
        logic selPol;    // select_polarity_setting: 1 active high
    } fwrp_cfg_s;

    // register write request to the register store
    typedef struct packed {
        logic [7:0] addr;  // {page, 7-bit address}
        logic [7:0] data;
    } fwrp_wr_s;

    typedef enum logic [2:0] {
        PH_IDLE,
        PH_CMD,
        PH_WRITE,
        PH_READ,
        PH_DONE
    } fwrp_phase_e;

endpackage

// file: verilog/fwrp_port.sv
`timescale 1ns/1ps
`default_nettype none

module fwrp_port
    import fwrp_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // configuration straps
    input  wire fwrp_cfg_s  cfg,
    // serial pins from the host
    input  wire logic       frameSelectLine,
    input  wire logic       hostSerialClock,
    input  wire logic       serialIn,
    // serial output pin, enable low while driving
    output logic            serialOut,
    output logic            serialOutEn_n,
    // register store side
    output var fwrp_wr_s    wrReq,
    output logic            wrStrobe,
    output logic [7:0]      rdAddr,
    input  wire logic [7:0] rdData,
    // page state
    output logic [7:0]      pageCtrl,
    output logic            activePage
);

    logic [2:0]  pinS1_q;        // first sync stage, read by stage two only
    logic [2:0]  pinS2_q;        // second sync stage
    logic [2:0]  pinS3_q;        // third sync stage
    logic [2:0]  pinF_q;         // filtered pin levels
    logic [2:0]  pinF_d;
    logic        sckPrev_q;      // filtered clock one cycle ago
    logic [4:0]  pipeFill_q;     // ones walk in after reset until pins are real
    fwrp_phase_e phase_q;        // frame phase
    fwrp_phase_e phase_d;
    logic [4:0]  bitCnt_q;       // samples taken in this frame
    logic [6:0]  frameIn_q;      // input shift register
    logic        addrZero_q;     // decoded address is page control
    logic        loaded_q;       // read byte loaded into output shifter
    logic [7:0]  outShift_q;     // read data shifter
    logic        serialOut_q;
    logic        serialOutEn_n_q;
    fwrp_wr_s    wrReq_q;
    logic        wrStrobe_q;
    logic [7:0]  rdAddr_q;
    logic [7:0]  pageCtrl_q;

    // decoding of pins and edges
    // the pin pipeline resets to zero, which may not be the idle level of select or clock,
    // so nothing is trusted until the pipeline and the edge history hold real pin values
    wire       pipeFull    = pipeFill_q[4];
    wire       selActive   = pipeFull & cfg.fourWire & (pinF_q[PIN_SEL] == cfg.selPol);
    wire       sckRise     = pinF_q[PIN_SCK] & ~sckPrev_q;
    wire       sckFall     = ~pinF_q[PIN_SCK] & sckPrev_q;
    wire       sampleOnFall = cfg.cpol ^ cfg.cpha;
    wire       sampleEdge  = sampleOnFall ? sckFall : sckRise;
    wire       shiftEdge   = sampleOnFall ? sckRise : sckFall;
    wire       siBit       = pinF_q[PIN_SI];
    wire [6:0] addrNow     = {frameIn_q[5:0], siBit};
    wire [7:0] dataNow     = {frameIn_q, siBit};
    wire       takeSample  = selActive & sampleEdge & (phase_q != PH_DONE) & (phase_q != PH_IDLE);
    wire       decodeNow   = takeSample & (bitCnt_q == LAST_ADDR_IX);
    wire       dirNow      = takeSample & (bitCnt_q == DIR_IX);
    wire       lastNow     = takeSample & (bitCnt_q == LAST_DATA_IX);
    wire       loadNow     = selActive & shiftEdge & (phase_q == PH_READ) & ~loaded_q;
    wire       shiftNow    = selActive & shiftEdge & (phase_q == PH_READ) & loaded_q;
    wire       commitNow   = lastNow & (phase_q == PH_WRITE);
    wire [7:0] readByte    = addrZero_q ? pageCtrl_q : rdData;

    // a bit counts once stages two and three agree; spikes shorter than a cycle vanish
    assign pinF_d = (~(pinS2_q ^ pinS3_q) & pinS3_q) | ((pinS2_q ^ pinS3_q) & pinF_q);

    // three-stage pin synchroniser and agreement filter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinS1_q   <= PIN_RST;
            pinS2_q   <= PIN_RST;
            pinS3_q   <= PIN_RST;
            pinF_q    <= PIN_RST;
            sckPrev_q <= 1'b0;
        end else begin
            pinS1_q   <= {serialIn, hostSerialClock, frameSelectLine};
            pinS2_q   <= pinS1_q;
            pinS3_q   <= pinS2_q;
            pinF_q    <= pinF_d;
            sckPrev_q <= pinF_q[PIN_SCK];
        end
    end

    // fill marker: five cycles cover three sync stages, the filter and the edge history
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pipeFill_q <= '0;
        end else begin
            pipeFill_q <= {pipeFill_q[3:0], 1'b1};
        end
    end

    // frame phase sequencing
    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE:  phase_d = PH_CMD;                                        // entered only when selected
            PH_CMD:   if (dirNow) begin
                          phase_d = (siBit == DIR_READ) ? PH_READ : PH_WRITE;
                      end
            PH_WRITE: if (lastNow) phase_d = PH_DONE;
            PH_READ:  if (lastNow) phase_d = PH_DONE;
            PH_DONE:  phase_d = PH_DONE;                                       // wait for deselect
            default:  phase_d = PH_IDLE;
        endcase
        if (!selActive) begin
            phase_d = PH_IDLE;
        end
    end

    // phase register and bit counter; deselect clears everything
    // the counter stops in the done phase, so late edges cannot wrap it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            phase_q  <= PH_IDLE;
            bitCnt_q <= BITCNT_RST;
        end else begin
            phase_q  <= phase_d;
            if (!selActive) begin
                bitCnt_q <= BITCNT_RST;
            end else if (takeSample) begin
                bitCnt_q <= bitCnt_q + 5'h01;
            end
        end
    end

    // input shifting and address decode
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            frameIn_q  <= 7'h00;
            addrZero_q <= 1'b0;
            rdAddr_q   <= 8'h00;
        end else begin
            if (takeSample) begin
                frameIn_q <= dataNow[6:0];
            end
            if (decodeNow) begin
                rdAddr_q   <= {pageCtrl_q[PAGE_SEL_BIT], addrNow};
                addrZero_q <= (addrNow == PAGE_CTRL_ADDR);
            end
        end
    end

    // read data output; drive only in the data half of a read frame
    // the line is released after the 16th sample, so a slow deselect never extends the drive
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loaded_q        <= 1'b0;
            outShift_q      <= 8'h00;
            serialOut_q     <= 1'b0;
            serialOutEn_n_q <= 1'b1;
        end else if (phase_d != PH_READ) begin
            loaded_q        <= 1'b0;
            serialOutEn_n_q <= 1'b1;
        end else if (loadNow) begin
            loaded_q        <= 1'b1;
            outShift_q      <= readByte;
            serialOut_q     <= readByte[7];
            serialOutEn_n_q <= 1'b0;
        end else if (shiftNow) begin
            outShift_q      <= {outShift_q[6:0], 1'b0};
            serialOut_q     <= outShift_q[6];
        end
    end

    // write commit; page control kept locally, others go to the store
    // a cut frame never gets here: deselect sends the phase back to idle first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pageCtrl_q <= PAGE_CTRL_RST;
            wrReq_q    <= '0;
            wrStrobe_q <= 1'b0;
        end else begin
            wrStrobe_q <= 1'b0;
            if (commitNow && addrZero_q) begin
                pageCtrl_q <= dataNow;
            end else if (commitNow) begin
                wrReq_q    <= '{addr: rdAddr_q, data: dataNow};
                wrStrobe_q <= 1'b1;
            end
        end
    end

    // outputs straight from flip-flops
    assign serialOut     = serialOut_q;
    assign serialOutEn_n = serialOutEn_n_q;
    assign wrReq         = wrReq_q;
    assign wrStrobe      = wrStrobe_q;
    assign rdAddr        = rdAddr_q;
    assign pageCtrl      = pageCtrl_q;
    assign activePage    = pageCtrl_q[PAGE_SEL_BIT];

endmodule // fwrp_port

`default_nettype wire

// file: verification/fwrp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fwrp_checker
    import fwrp_pkg::*;
(
    // clock, reset, straps
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire fwrp_cfg_s  cfg,
    // pins
    input wire logic       frameSelectLine,
    input wire logic       hostSerialClock,
    input wire logic       serialOut,
    input wire logic       serialOutEn_n,
    // store and page side
    input wire fwrp_wr_s   wrReq,
    input wire logic       wrStrobe,
    input wire logic [7:0] rdAddr,
    input wire logic [7:0] pageCtrl,
    input wire logic       activePage
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // raw pin view; seven cycles covers the synchroniser lag
    wire logic selAct = cfg.fourWire && (frameSelectLine == cfg.selPol);
    sequence quiet_s; !selAct [*7]; endsequence
    sequence steady_s; (!serialOutEn_n && $stable(hostSerialClock)) [*7]; endsequence
    strobe_pulse_a: assert property (wrStrobe |=> !wrStrobe) else $error("strobe too long");
    page_bit_a: assert property (quiet_s |-> $stable(pageCtrl) && activePage == pageCtrl[PAGE_SEL_BIT])
        else $error("page moved while idle");
    zero_addr_a: assert property (wrStrobe |-> wrReq.addr[6:0] != PAGE_CTRL_ADDR) else $error("addr zero stored");
    wr_page_a: assert property (wrStrobe |-> wrReq.addr[7] == activePage) else $error("write page");
    page_write_a: assert property ($changed(pageCtrl) |-> rdAddr[6:0] == PAGE_CTRL_ADDR)
        else $error("page moved");
    decode_page_a: assert property ($changed(rdAddr) |-> rdAddr[7] == activePage) else $error("decode page");
    idle_hiz_a: assert property (quiet_s |-> serialOutEn_n && !wrStrobe) else $error("active while idle");
    out_hold_a: assert property (steady_s |-> $stable(serialOut)) else $error("output moved");
    en_drop_a: assert property ($fell(serialOutEn_n) |-> selAct && !wrStrobe) else $error("bad drive");
endmodule // fwrp_checker
bind fwrp_port fwrp_checker fwrp_checker_inst (.sys_clk(sys_clk), .rst(rst), .cfg(cfg),
    .frameSelectLine(frameSelectLine), .hostSerialClock(hostSerialClock), .serialOut(serialOut),
    .serialOutEn_n(serialOutEn_n), .wrReq(wrReq), .wrStrobe(wrStrobe), .rdAddr(rdAddr),
    .pageCtrl(pageCtrl), .activePage(activePage));
`default_nettype wire

// file: verification/fwrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module fwrp_host
    import fwrp_pkg::*;
(
    // bench clock and straps
    input  wire logic      sys_clk,
    input  wire fwrp_cfg_s cfg,
    // serial pins
    output var logic       sel,
    output var logic       sck,
    output var logic       si,
    input  wire logic      so
);
    logic [15:0] w; // frame word
    initial begin
        sel = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // idle levels for the current straps
    task automatic park();
        sel = ~cfg.selPol;
        sck = cfg.cpol;
    endtask
    // released data line toggles, never holds its last value
    task automatic put(input int i);
        si = (i < 8 || !w[8]) ? w[15 - i] : ~si;
    endtask
    // one frame; n below 16 aborts it; capture lags the edge to allow for the device's synchroniser
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d, input int n,
                        output logic [7:0] q);
        w = {a, rd, d};
        q = 8'h00;
        sel = cfg.selPol;
        for (int i = 0; i < n; i++) begin
            if (!cfg.cpha) put(i);
            repeat (2) @(negedge sys_clk);
            if (cfg.cpha && i > 8) q = {q[6:0], so};
            repeat (2) @(negedge sys_clk);
            sck = ~sck;
            if (cfg.cpha) put(i);
            repeat (2) @(negedge sys_clk);
            if (!cfg.cpha && i > 7) q = {q[6:0], so};
            repeat (2) @(negedge sys_clk);
            sck = ~sck;
        end
        repeat (2) @(negedge sys_clk);
        if (cfg.cpha && n == 16) q = {q[6:0], so};
        repeat (2) @(negedge sys_clk);
        sel = ~cfg.selPol;
        si = ~si;
        repeat (8) @(negedge sys_clk);
    endtask
endmodule // fwrp_host
`default_nettype wire

// file: verification/fwrp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fwrp_port_bench
    import fwrp_pkg::*;
;
    logic       sys_clk, rst, so, wrStrobe, serialOut, serialOutEn_n, activePage, sel, sck, si;
    fwrp_cfg_s  cfg;
    fwrp_wr_s   wrReq, lastWr;
    logic [7:0] rdAddr, rdData, pageCtrl, q;
    logic [7:0] mem [256]; // register store beside the port
    int         fails, total_checks, nWr, cyc;
    assign so = serialOutEn_n ? 1'bz : serialOut; // undriven pin floats
    assign rdData = mem[rdAddr];
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // store writes, strobe count, hang guard
    // a frame takes about 140 cycles and the run about 20 frames, far below the ceiling
    always @(posedge sys_clk) begin
        if (wrStrobe) begin
            nWr++;
            lastWr = wrReq;
            mem[wrReq.addr] = wrReq.data;
        end
        cyc++;
        if (cyc == 10000) begin
            fails++;
            end_sim();
        end
    end
    fwrp_port fwrp_port_inst (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .frameSelectLine(sel),
        .hostSerialClock(sck), .serialIn(si), .serialOut(serialOut), .serialOutEn_n(serialOutEn_n),
        .wrReq(wrReq), .wrStrobe(wrStrobe), .rdAddr(rdAddr), .rdData(rdData), .pageCtrl(pageCtrl),
        .activePage(activePage));
    fwrp_host fwrp_host_inst (.sys_clk(sys_clk), .cfg(cfg), .sel(sel), .sck(sck), .si(si), .so(so));
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run(input logic [6:0] a, input logic rd, input logic [7:0] d, input int n = 16);
        fwrp_host_inst.xfer(a, rd, d, n, q);
    endtask
    initial begin
        logic [1:0] mm;
        cfg = 4'h8;
        rst = 1'b1;
        mem = '{default: 8'h00};
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("page after reset", {activePage, pageCtrl}, {1'b0, PAGE_CTRL_RST});
        // every clock mode, select polarity flipping too
        for (int m = 0; m < 4; m++) begin
            mm = m[1:0];
            cfg = {1'b1, mm, mm[0]};
            fwrp_host_inst.park();
            repeat (8) @(negedge sys_clk);
            run({5'h15, mm}, 1'b0, {6'h29, mm});
            chk("write request", lastWr, {1'b0, 5'h15, mm, 6'h29, mm});
            run(7'h00, 1'b1, 8'h00);
            chk("spacer page read", q, 8'h00);
            run({5'h15, mm}, 1'b1, 8'h00);
            chk("read data", q, {6'h29, mm});
            $display("mode %0d done", m);
        end
        // paging on the last mode
        run(7'h00, 1'b1, 8'h00);
        chk("page read", q, 8'h00);
        run(7'h00, 1'b0, 8'h01);
        chk("page write", {activePage, pageCtrl}, {1'b1, 8'h01});
        chk("no store write", 16'(nWr), 16'h0004);
        run(7'h00, 1'b1, 8'h00);
        chk("page readback", q, 8'h01);
        run(7'h54, 1'b0, 8'h5a);
        chk("second page write", lastWr, {1'b1, 7'h54, 8'h5a});
        run(7'h00, 1'b1, 8'h00);
        chk("page kept", q, 8'h01);
        run(7'h54, 1'b1, 8'h00);
        chk("second page read", q, 8'h5a);
        // aborted frame, then a disabled port
        run(7'h33, 1'b0, 8'hff, 12);
        chk("partial frame", 16'(nWr), 16'h0005);
        cfg.fourWire = 1'b0;
        run(7'h33, 1'b0, 8'hff);
        chk("port disabled", 16'(nWr), 16'h0005);
        $display("page and abort tests done");
        end_sim();
    end
endmodule // fwrp_port_bench
`default_nettype wire
